// ---- psc_defs.vh ----
// timing constants and field layout for the pseudo-static memory controller
`ifndef PSC_DEFS_VH
`define PSC_DEFS_VH
`define PSC_CLK_NS 40
`define PSC_ADDR_W 21
`define PSC_DATA_W 16
`define PSC_PAGE_BITS 3
`define PSC_PAGE_WORDS 8
// times in their own units, faster grade
`define PSC_READ_CYCLE_NS 65
`define PSC_WRITE_CYCLE_NS 65
`define PSC_WRITE_PULSE_NS 50
`define PSC_SEL_TO_WEND_NS 65
`define PSC_ADDR_TO_WEND_NS 60
`define PSC_WFLOAT_NS 20
`define PSC_OE_DELAY_NS 25
`define PSC_PAGE_STEP_NS 30
`define PSC_PAGE_WORD_NS 30
`define PSC_SKEW_US 10
`define PSC_SLEEP_LOW_MS 10
`define PSC_SLEEP_EXIT_US 300
`define PSC_POWERUP_US 30
// cycle counts: minimums round up, skew window rounds down
`define PSC_CYC_MIN(ns) (((ns) + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`define PSC_READ_CYC `PSC_CYC_MIN(`PSC_READ_CYCLE_NS)
`define PSC_WRITE_CYC `PSC_CYC_MIN(`PSC_WRITE_CYCLE_NS)
`define PSC_WPULSE_CYC `PSC_CYC_MIN(`PSC_WRITE_PULSE_NS)
`define PSC_SEL_WEND_CYC `PSC_CYC_MIN(`PSC_SEL_TO_WEND_NS)
`define PSC_ADDR_WEND_CYC `PSC_CYC_MIN(`PSC_ADDR_TO_WEND_NS)
`define PSC_WFLOAT_CYC `PSC_CYC_MIN(`PSC_WFLOAT_NS)
`define PSC_OE_CYC `PSC_CYC_MIN(`PSC_OE_DELAY_NS)
`define PSC_PSTEP_CYC `PSC_CYC_MIN(`PSC_PAGE_STEP_NS)
`define PSC_PWORD_CYC `PSC_CYC_MIN(`PSC_PAGE_WORD_NS)
`define PSC_SKEW_CYC ((`PSC_SKEW_US * 1000) / `PSC_CLK_NS)
`define PSC_SLEEP_LOW_CYC ((`PSC_SLEEP_LOW_MS * 1000000 + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`define PSC_SLEEP_EXIT_CYC ((`PSC_SLEEP_EXIT_US * 1000 + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`define PSC_POWERUP_CYC ((`PSC_POWERUP_US * 1000 + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`define PSC_TMR_W 20
`endif

// ---- psc_timer.v ----
// down-counting phase timer with a done flag
`timescale 1ns/1ns
`include "psc_defs.vh"
module psc_timer (
	clk,
	rst,
	load,
	load_val,
	done
);
	input wire clk;
	input wire rst;
	input wire load;
	input wire [`PSC_TMR_W-1:0] load_val;
	output wire done;
	reg [`PSC_TMR_W-1:0] cnt_q;
	// load takes priority; otherwise count down to zero and rest
	always @(posedge clk) begin
		if (rst) begin
			cnt_q <= 20'h0_0000;
		end else if (load) begin
			cnt_q <= load_val;
		end else if (cnt_q != 20'h0_0000) begin
			cnt_q <= cnt_q - 20'h0_0001;
		end
	end
	assign done = (cnt_q == 20'h0_0000) && !load;
endmodule

// ---- psc_ctrl.v ----
// host controller pacing asynchronous accesses to a 2M x 16 pseudo-static memory
// Function
// (R1) memory decodes modes from select and power_keep; standby floats its outputs
// (R2) byte selects gate lanes; deselected write lane keeps its stored byte
// (R3) page holds 8 words chosen by three lowest address bits
// (R4) page burst changes only in-page bits, select held low throughout
// (R5) short read address cycles never run; each cycle meets full read length
// (R6) each write cycle meets full write length and full write pulse
// (R7) deep power-down loses contents; host flags data as undefined after exit
// (R8) power_keep low at least 10 ms; wait 300 us before next access
// (R9) after power-on hold power_keep high 30 us before first access
// (R10) write ends at first rising edge of enable, select or byte selects
// (R11) select asserted at least 65 ns before the end of write
// (R12) address stable at least 60 ns before the write-ending edge
// (R13) output enable held high through writes keeps memory outputs floating
// (R14) select and bytes fall with write enable so memory never drives
// (R15) selects rise with write enable so outputs stay floating at the end
// (R16) memory floats its outputs within 20 ns of write enable falling
// (R17) host drives write data only after memory outputs have floated
// (R18) read data sampled after output-enable and address access times
// (R19) in-page word sampled at least 30 ns after the address step
// (R20) in-page address steps spaced at least 30 ns apart
// (R21) previous read data held 10 ns after address change
// (R22) every phase length is a clock-cycle count, minimums rounded up
`timescale 1ns/1ns
`include "psc_defs.vh"
module psc_ctrl (
	clk,
	rst,
	req_valid,
	req_write,
	req_sleep,
	req_addr,
	req_wdata,
	req_bytes_n,
	req_len,
	req_ready,
	rsp_valid,
	rsp_data,
	rsp_last,
	mem_undefined,
	mem_addr,
	chip_select_n,
	power_keep,
	output_enable_n,
	write_enable_n,
	lower_byte_select_n,
	upper_byte_select_n,
	dq_out,
	dq_oe,
	dq_in
);
	input wire clk;
	input wire rst;
	input wire req_valid;
	input wire req_write;
	input wire req_sleep;
	input wire [`PSC_ADDR_W-1:0] req_addr;
	input wire [`PSC_DATA_W-1:0] req_wdata;
	input wire [1:0] req_bytes_n;
	input wire [2:0] req_len;
	output reg req_ready;
	output reg rsp_valid;
	output reg [`PSC_DATA_W-1:0] rsp_data;
	output reg rsp_last;
	output reg mem_undefined;
	output reg [`PSC_ADDR_W-1:0] mem_addr;
	output reg chip_select_n;
	output reg power_keep;
	output reg output_enable_n;
	output reg write_enable_n;
	output reg lower_byte_select_n;
	output reg upper_byte_select_n;
	output reg [`PSC_DATA_W-1:0] dq_out;
	output reg dq_oe;
	input wire [`PSC_DATA_W-1:0] dq_in;

	// ----------------------------------------
	// states and cycle counts
	// ----------------------------------------
	localparam [3:0] ST_POWERUP = 4'h0;
	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_RD_FIRST = 4'h2;
	localparam [3:0] ST_RD_PAGE = 4'h3;
	localparam [3:0] ST_RD_END = 4'h4;
	localparam [3:0] ST_WR_FLOAT = 4'h5;
	localparam [3:0] ST_WR_PULSE = 4'h6;
	localparam [3:0] ST_WR_END = 4'h7;
	localparam [3:0] ST_SLEEP = 4'h8;
	localparam [3:0] ST_WAKE = 4'h9;
	// full-width counts, cut to the timer width below
	localparam integer K_POWERUP = `PSC_POWERUP_CYC;
	localparam integer K_SLEEP = `PSC_SLEEP_LOW_CYC;
	localparam integer K_WAKE = `PSC_SLEEP_EXIT_CYC;
	localparam integer K_WFLOAT = `PSC_WFLOAT_CYC;
	localparam integer K_PSTEP = `PSC_PSTEP_CYC;
	localparam integer K_PWORD = `PSC_PWORD_CYC;
	localparam integer K_RD_CYC = `PSC_READ_CYC;
	localparam integer K_OE_CYC = `PSC_OE_CYC;
	localparam integer K_WPULSE = `PSC_WPULSE_CYC;
	localparam integer K_WCYC = `PSC_WRITE_CYC;
	localparam integer K_SELW = `PSC_SEL_WEND_CYC;
	localparam integer K_ADRW = `PSC_ADDR_WEND_CYC;
	localparam [19:0] C_POWERUP = K_POWERUP[19:0];
	localparam [19:0] C_SLEEP = K_SLEEP[19:0];
	localparam [19:0] C_WAKE = K_WAKE[19:0];
	localparam [19:0] C_WFLOAT = K_WFLOAT[19:0];
	localparam [19:0] C_PSTEP = K_PSTEP[19:0];
	localparam [19:0] C_PWORD = K_PWORD[19:0];
	localparam [19:0] C_RD_CYC = K_RD_CYC[19:0];
	localparam [19:0] C_OE_CYC = K_OE_CYC[19:0];
	localparam [19:0] C_WPULSE = K_WPULSE[19:0];
	localparam [19:0] C_WCYC = K_WCYC[19:0];
	localparam [19:0] C_SELW = K_SELW[19:0];
	localparam [19:0] C_ADRW = K_ADRW[19:0];

	// larger of two counts; used for every composite phase
	function [19:0] max2;
		input [19:0] a;
		input [19:0] b;
		begin
			max2 = (a > b) ? a : b;
		end
	endfunction

	reg [3:0] state_q;
	reg [2:0] words_q;
	reg tmr_load;
	reg [19:0] tmr_val;
	wire tmr_done;

	psc_timer u_timer (
		.clk(clk),
		.rst(rst),
		.load(tmr_load),
		.load_val(tmr_val),
		.done(tmr_done)
	);

	// ----------------------------------------
	// phase sequencer
	// ----------------------------------------
	always @(posedge clk) begin
		tmr_load <= 1'b0;
		tmr_val <= 20'h0_0000;
		rsp_valid <= 1'b0;
		rsp_last <= 1'b0;
		if (rst) begin
			state_q <= ST_POWERUP;
			words_q <= 3'h0;
			req_ready <= 1'b0;
			mem_undefined <= 1'b0;
			mem_addr <= 21'h00_0000;
			chip_select_n <= 1'b1;
			power_keep <= 1'b1;
			output_enable_n <= 1'b1;
			write_enable_n <= 1'b1;
			lower_byte_select_n <= 1'b1;
			upper_byte_select_n <= 1'b1;
			dq_out <= 16'h0000;
			dq_oe <= 1'b0;
			rsp_data <= 16'h0000;
			tmr_load <= 1'b1;
			tmr_val <= C_POWERUP; // R9 R22
		end else if (!tmr_load) begin
			case (state_q)
			ST_POWERUP, ST_WAKE: begin
				if (tmr_done) begin // R8 R9
					state_q <= ST_IDLE;
					req_ready <= 1'b1;
				end
			end
			ST_IDLE: begin
				if (req_valid) begin
					req_ready <= 1'b0;
					mem_addr <= req_addr;
					tmr_load <= 1'b1;
					if (req_sleep) begin
						// enter deep power-down with the chip deselected
						chip_select_n <= 1'b1; // R1
						power_keep <= 1'b0;
						mem_undefined <= 1'b1; // R7
						tmr_val <= C_SLEEP; // R8
						state_q <= ST_SLEEP;
					end else if (req_write) begin
						// select, bytes and write enable go low together
						chip_select_n <= 1'b0;
						write_enable_n <= 1'b0; // R14
						output_enable_n <= 1'b1; // R13
						lower_byte_select_n <= req_bytes_n[0]; // R2
						upper_byte_select_n <= req_bytes_n[1];
						dq_out <= req_wdata;
						tmr_val <= C_WFLOAT; // R16 R17
						state_q <= ST_WR_FLOAT;
					end else begin
						chip_select_n <= 1'b0;
						output_enable_n <= 1'b0;
						lower_byte_select_n <= req_bytes_n[0]; // R2
						upper_byte_select_n <= req_bytes_n[1];
						words_q <= req_len;
						// first word waits the longer of the full read cycle and the oe access
						tmr_val <= max2(C_RD_CYC, C_OE_CYC); // R5 R18
						state_q <= ST_RD_FIRST;
					end
				end
			end
			ST_RD_FIRST, ST_RD_PAGE: begin
				if (tmr_done) begin
					rsp_valid <= 1'b1;
					rsp_data <= dq_in; // R18 R19 R21
					if (words_q == 3'h0) begin
						rsp_last <= 1'b1;
						state_q <= ST_RD_END;
					end else begin
						words_q <= words_q - 3'h1;
						// step only the in-page bits, select stays low
						mem_addr[`PSC_PAGE_BITS-1:0] <= mem_addr[`PSC_PAGE_BITS-1:0] + 3'h1; // R3 R4
						tmr_load <= 1'b1;
						tmr_val <= max2(C_PSTEP, C_PWORD); // R20 R19
						state_q <= ST_RD_PAGE;
					end
				end
			end
			ST_RD_END: begin
				chip_select_n <= 1'b1;
				output_enable_n <= 1'b1;
				lower_byte_select_n <= 1'b1;
				upper_byte_select_n <= 1'b1;
				req_ready <= 1'b1;
				state_q <= ST_IDLE;
			end
			ST_WR_FLOAT: begin
				if (tmr_done) begin
					dq_oe <= 1'b1; // R17
					tmr_load <= 1'b1;
					// remainder so pulse, select and address spans are all met
					tmr_val <= max2(max2(C_WPULSE, C_WCYC), max2(C_SELW, C_ADRW)) - C_WFLOAT;
					state_q <= ST_WR_PULSE; // R6 R11 R12
				end
			end
			ST_WR_PULSE: begin
				if (tmr_done) begin
					// all strobes rise together; write enable defines the end
					write_enable_n <= 1'b1; // R10
					chip_select_n <= 1'b1; // R15
					lower_byte_select_n <= 1'b1;
					upper_byte_select_n <= 1'b1;
					state_q <= ST_WR_END;
				end
			end
			ST_WR_END: begin
				dq_oe <= 1'b0; // hold time zero, release one cycle later
				req_ready <= 1'b1;
				state_q <= ST_IDLE;
			end
			ST_SLEEP: begin
				if (tmr_done) begin
					power_keep <= 1'b1;
					tmr_load <= 1'b1;
					tmr_val <= C_WAKE; // R8
					state_q <= ST_WAKE;
				end
			end
			default: begin
				state_q <= ST_IDLE;
				req_ready <= 1'b1;
			end
			endcase
			// a completed write clears the undefined flag for software
			if (state_q == ST_WR_END) begin
				mem_undefined <= 1'b0;
			end
		end
	end
endmodule

// ---- psc_ctrl_chk.sv ----
// pin timing checker for the memory controller
`timescale 1ns/1ns
`include "psc_defs.vh"
module psc_ctrl_chk (
	input logic clk,
	input logic rst,
	input logic req_ready,
	input logic rsp_valid,
	input logic [`PSC_ADDR_W-1:0] mem_addr,
	input logic chip_select_n,
	input logic output_enable_n,
	input logic write_enable_n,
	input logic dq_oe,
	input logic power_keep
);
	int up_q;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// cycles since reset release, saturating
	always @(posedge clk) begin
		if (rst)
			up_q <= 0;
		else if (up_q < 100000)
			up_q <= up_q + 1;
	end
	property p_wake; req_ready |-> up_q >= `PSC_POWERUP_CYC - 1; endproperty
	a_wake: assert property (p_wake) else $error("ready before wake wait");
	property p_fight; dq_oe |-> output_enable_n; endproperty
	a_fight: assert property (p_fight) else $error("data driven with oe low");
	property p_oe_wr; !write_enable_n |-> output_enable_n; endproperty
	a_oe_wr: assert property (p_oe_wr) else $error("oe low in write");
	property p_pulse; $fell(write_enable_n) |-> (!write_enable_n && !chip_select_n)[*2]; endproperty
	a_pulse: assert property (p_pulse) else $error("write pulse short");
	property p_start; $fell(write_enable_n) |-> $fell(chip_select_n); endproperty
	a_start: assert property (p_start) else $error("select not with enable");
	property p_end; $rose(write_enable_n) |-> chip_select_n; endproperty
	a_end: assert property (p_end) else $error("select not released");
	property p_addr; !write_enable_n && $past(!write_enable_n) |-> $stable(mem_addr); endproperty
	a_addr: assert property (p_addr) else $error("address moved in write");
	property p_float; $rose(dq_oe) |-> $past(!write_enable_n); endproperty
	a_float: assert property (p_float) else $error("data before float");
	property p_acc; rsp_valid |-> $past(!output_enable_n) && $past(!chip_select_n, 2); endproperty
	a_acc: assert property (p_acc) else $error("read sampled early");
	property p_page;
		!chip_select_n && $past(!chip_select_n) |->
			$stable(mem_addr[`PSC_ADDR_W-1:`PSC_PAGE_BITS]);
	endproperty
	a_page: assert property (p_page) else $error("page moved");
	property p_sleep; !power_keep |-> chip_select_n; endproperty
	a_sleep: assert property (p_sleep) else $error("selected in power-down");
	c_rd: cover property (rsp_valid);
	c_wr: cover property ($rose(dq_oe));
	c_step: cover property (rsp_valid ##3 rsp_valid);
	c_sleep: cover property ($fell(power_keep));
endmodule
bind psc_ctrl psc_ctrl_chk u_chk (.clk(clk), .rst(rst), .req_ready(req_ready),
	.rsp_valid(rsp_valid), .mem_addr(mem_addr), .chip_select_n(chip_select_n),
	.output_enable_n(output_enable_n), .write_enable_n(write_enable_n), .dq_oe(dq_oe),
	.power_keep(power_keep));

// ---- psc_mem_model.sv ----
// behavioural pseudo-static memory on the controller pins
`timescale 1ns/1ns
`include "psc_defs.vh"
module psc_mem_model (
	input logic [`PSC_ADDR_W-1:0] mem_addr,
	input logic chip_select_n,
	input logic power_keep,
	input logic output_enable_n,
	input logic write_enable_n,
	input logic lower_byte_select_n,
	input logic upper_byte_select_n,
	input logic [`PSC_DATA_W-1:0] dq_out,
	input logic dq_oe,
	output logic [`PSC_DATA_W-1:0] dq_in
);
	logic [15:0] mem [0:255];
	logic [15:0] wd;
	logic [15:0] last = 16'h0000;
	logic [7:0] wa;
	logic [1:0] wl;
	logic rd_on;
	logic wr_on;
	// mode decode; standby and sleep float
	assign rd_on = !chip_select_n && power_keep && !output_enable_n && write_enable_n;
	assign wr_on = !chip_select_n && power_keep && !write_enable_n;
	// track the open write, commit by lane when it ends
	always @* if (wr_on) begin
		wd = dq_in;
		wa = mem_addr[7:0];
		wl = {upper_byte_select_n, lower_byte_select_n};
	end
	always @(negedge wr_on) begin
		if (!wl[0]) mem[wa][7:0] = wd[7:0];
		if (!wl[1]) mem[wa][15:8] = wd[15:8];
	end
	// sleep loses contents
	always @(negedge power_keep) for (int i = 0; i < 256; i++) mem[i] = 16'h5a5a;
	// read word: old data held, then unsettled, then the new word
	always @(mem_addr or rd_on) begin
		if (rd_on) begin
			#10 last = ~last;
			#20 last = mem[mem_addr[7:0]];
		end
	end
	// wire level: memory lanes, host, else drifting inverse
	always @* begin
		dq_in = ~last;
		if (rd_on && !lower_byte_select_n) dq_in[7:0] = last[7:0];
		if (rd_on && !upper_byte_select_n) dq_in[15:8] = last[15:8];
		if (dq_oe) dq_in = rd_on ? 16'hxxxx : dq_out;
	end
endmodule

// ---- psram_async_access_timing_tb.sv ----
// self-checking bench for the memory controller
`timescale 1ns/1ns
`include "psc_defs.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module psram_async_access_timing_tb;
	logic clk = 0, rst = 1, req_valid = 0, req_write = 0, req_sleep = 0;
	logic [20:0] req_addr = 0, mem_addr;
	logic [15:0] req_wdata = 0, rsp_data, dq_out, dq_in;
	logic [1:0] req_bytes_n = 0;
	logic [2:0] req_len = 0;
	logic req_ready, rsp_valid, rsp_last, mem_undefined, chip_select_n, power_keep, dq_oe;
	logic output_enable_n, write_enable_n, lower_byte_select_n, upper_byte_select_n;
	logic [15:0] shadow [0:255];
	int errors = 0, n_tests = 0;
	always #20 clk = ~clk;
	psc_ctrl u_dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
		.req_sleep(req_sleep), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_bytes_n(req_bytes_n), .req_len(req_len), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last),
		.mem_undefined(mem_undefined), .mem_addr(mem_addr), .chip_select_n(chip_select_n),
		.power_keep(power_keep), .output_enable_n(output_enable_n),
		.write_enable_n(write_enable_n), .lower_byte_select_n(lower_byte_select_n),
		.upper_byte_select_n(upper_byte_select_n), .dq_out(dq_out), .dq_oe(dq_oe),
		.dq_in(dq_in));
	psc_mem_model u_mem (.mem_addr(mem_addr), .chip_select_n(chip_select_n),
		.power_keep(power_keep), .output_enable_n(output_enable_n),
		.write_enable_n(write_enable_n), .lower_byte_select_n(lower_byte_select_n),
		.upper_byte_select_n(upper_byte_select_n), .dq_out(dq_out), .dq_oe(dq_oe),
		.dq_in(dq_in));
	task results;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// hold one request until it is taken
	task automatic request(logic wr, logic [20:0] a, logic [15:0] d, logic [1:0] b, logic [2:0] n);
		int k;
		@(posedge clk);
		req_valid <= 1'b1;
		req_write <= wr;
		req_addr <= a;
		req_wdata <= d;
		req_bytes_n <= b;
		req_len <= n;
		// ready is read at the same edge at which the request is taken
		for (k = 0; k < 2000; k++) begin
			@(posedge clk);
			if (req_ready) break;
		end
		if (k == 2000) begin
			errors++;
			results();
		end
		req_valid <= 1'b0;
	endtask
	task automatic wr(logic [20:0] a, logic [15:0] d, logic [1:0] b);
		request(1'b1, a, d, b, 3'h0);
		if (!b[0]) shadow[a[7:0]][7:0] = d[7:0];
		if (!b[1]) shadow[a[7:0]][15:8] = d[15:8];
	endtask
	// burst read, expected words wrap inside the page
	task automatic rd(logic [20:0] a, logic [2:0] n);
		int k;
		request(1'b0, a, 16'h0000, 2'b00, n);
		for (int i = 0; i <= n; i++) begin
			for (k = 0; k < 20 && !rsp_valid; k++) @(posedge clk);
			if (k == 20) begin
				errors++;
				results();
			end
			`CHK("rsp_data", shadow[{a[7:3], a[2:0] + i[2:0]}], rsp_data)
			`CHK("rsp_last", (i == n), rsp_last)
			@(posedge clk);
		end
	endtask
	// deep power-down entry: select high, flag set, power_keep held low
	task automatic sleep_entry;
		int k;
		req_sleep <= 1'b1;
		request(1'b0, 21'h00_0000, 16'h0000, 2'b11, 3'h0);
		req_sleep <= 1'b0;
		@(posedge clk);
		`CHK("sleep_keep", 1'b0, power_keep)
		`CHK("sleep_select", 1'b1, chip_select_n)
		`CHK("sleep_undef", 1'b1, mem_undefined)
		for (k = 0; k < 2000 && !power_keep && !req_ready; k++) @(posedge clk);
		`CHK("sleep_hold", 2000, k)
	endtask
	initial begin
		int k;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		for (k = 0; k < 2000 && !req_ready; k++) @(posedge clk);
		if (k == 2000) begin
			errors++;
			results();
		end
		`CHK("wake_wait", 1'b1, k >= `PSC_POWERUP_CYC - 1)
		`CHK("undef_reset", 1'b0, mem_undefined)
		`CHK("keep_reset", 1'b1, power_keep)
		`CHK("select_reset", 1'b1, chip_select_n)
		$display("done powerup");
		wr(21'h0010, 16'ha5c3, 2'b00);
		rd(21'h0010, 3'h0);
		$display("done word");
		wr(21'h0011, 16'h1111, 2'b00);
		wr(21'h0011, 16'h22ee, 2'b10);
		wr(21'h0011, 16'h3344, 2'b01);
		rd(21'h0011, 3'h0);
		$display("done lanes");
		for (int i = 0; i < 8; i++) wr(21'h0040 + i, 16'hc000 + i * 16'h0111, 2'b00);
		rd(21'h0045, 3'h7);
		rd(21'h0047, 3'h0);
		rd(21'h0040, 3'h7);
		$display("done page");
		sleep_entry();
		$display("done sleep");
		results();
	end
endmodule
